//--- common/adlgc_cfg.svh
// register offsets, field positions and reset values for the aux converter and io line block
`ifndef ADLGC_CFG_SVH
`define ADLGC_CFG_SVH
`define ADLGC_OFS_CODE_LO   7'h30
`define ADLGC_OFS_CODE_HI   7'h31
`define ADLGC_OFS_IOCTL_LO  7'h32
`define ADLGC_OFS_IOCTL_HI  7'h33
`define ADLGC_CODE_RESET    12'h000
`define ADLGC_CODE_HI_MASK  8'h0f
`define ADLGC_IOCTL_LO_MASK 8'h03
`define ADLGC_IOCTL_HI_MASK 8'h03
`define ADLGC_LATCH_BIT     2
`define ADLGC_DIR_RESET     2'h0
`define ADLGC_LVL_RESET     2'h0
`endif

//--- common/adlgc_pkg.sv
// types shared by the aux converter and io line block
package adlgc_pkg;
  typedef enum logic [1:0] {
    ADLGC_SRC_GPIO  = 2'b00,
    ADLGC_SRC_ALARM = 2'b01,
    ADLGC_SRC_MISC  = 2'b10
  } adlgc_src_t;
endpackage : adlgc_pkg

//--- hdl/adlgc_aux_dac_gpio.sv
// aux converter code register with latch command, and two-line io controller with priority arbitration
//
// Behaviour
// RQ1 - the converter code is a 12-bit unsigned value in bits 11:0 with bits 15:12 unused.
// RQ2 - written code bytes reach the converter only when bit 2 of the command byte is written as 1, both at once.
// RQ3 - the host writes both code bytes and then issues the latch command, so the output moves in one step.
// RQ4 - the code is straight binary from zero to 0x0fff full scale, the analog stage scaling it linearly.
// RQ5 - the code register is volatile, clears to zero on reset and is readable and writable.
// RQ6 - control bits 0 and 1 set the direction of lines zero and one, 1 meaning output.
// RQ7 - control bits 8 and 9 set the driven level of lines zero and one.
// RQ8 - control bits 15:10 and 7:2 are unused.
// RQ9 - miscellaneous control wins over alarm control, which wins over the io control register.
// RQ10 - the io control register clears to zero on reset so both lines come up as inputs.
// RQ11 - an enabled sample available signal drives line one if its select bit is 1, else line zero.
// RQ12 - writes to unused bits are ignored and those bits read as zero.
`timescale 1ns/1ps
`include "adlgc_cfg.svh"

module adlgc_aux_dac_gpio #(
  parameter int ADDR_W = 7,
  parameter int CODE_W = 12
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWdata,
  output logic      [7:0]        regRdata,
  input  wire logic              cmdWrite,
  input  wire logic [7:0]        cmdWdata,
  output logic      [CODE_W-1:0] converterCode,
  input  wire logic              sampleAvailableEnable,
  input  wire logic              sampleAvailableSelect,
  input  wire logic              sampleAvailableLevel,
  input  wire logic [1:0]        alarmOwn,
  input  wire logic [1:0]        alarmLevel,
  input  wire logic              ioLineZeroIn,
  input  wire logic              ioLineOneIn,
  output logic                   ioLineZeroOut,
  output logic                   ioLineZeroOe,
  output logic                   ioLineOneOut,
  output logic                   ioLineOneOe,
  output logic      [1:0]        ioLineSync
);

  // ==========================================================
  // register state
  logic [CODE_W-1:0] codeStage;
  logic [CODE_W-1:0] next_codeStage;
  logic [CODE_W-1:0] next_converterCode;
  logic [1:0]        ioDir;
  logic [1:0]        next_ioDir;
  logic [1:0]        ioLevel;
  logic [1:0]        next_ioLevel;
  logic [7:0]        next_regRdata;
  logic              hitCodeLo;
  logic              hitCodeHi;
  logic              hitIoLo;
  logic              hitIoHi;
  logic              latchReq;

  // ==========================================================
  // helper functions

  // true when a byte address selects the given register byte
  function automatic logic adlgcHit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    adlgcHit = (addr == ofs);
  endfunction : adlgcHit

  // keeps only the used bits of a register byte
  function automatic logic [7:0] adlgcKeep(
    input logic [7:0] data,
    input logic [7:0] mask
  );
    adlgcKeep = data & mask;
  endfunction : adlgcKeep

  // ==========================================================
  // address and command decode

  always_comb begin
    hitCodeLo = adlgcHit(regAddr, `ADLGC_OFS_CODE_LO);
    hitCodeHi = adlgcHit(regAddr, `ADLGC_OFS_CODE_HI);
    hitIoLo   = adlgcHit(regAddr, `ADLGC_OFS_IOCTL_LO);
    hitIoHi   = adlgcHit(regAddr, `ADLGC_OFS_IOCTL_HI);
    // RQ2 only bit 2 of the command byte latches
    latchReq  = cmdWrite && cmdWdata[`ADLGC_LATCH_BIT];
  end

  // ==========================================================
  // converter code staging

  always_comb begin
    next_codeStage = codeStage;
    if (regWrite && hitCodeLo) begin
      next_codeStage[7:0] = regWdata;
    end
    // RQ1 RQ12 upper nibble dropped
    if (regWrite && hitCodeHi) begin
      next_codeStage[CODE_W-1:8] = regWdata[CODE_W-9:0];
    end
  end

  // RQ5 staged code clears on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      codeStage <= `ADLGC_CODE_RESET;
    end else begin
      codeStage <= next_codeStage;
    end
  end

  // ==========================================================
  // converter latch

  always_comb begin
    next_converterCode = converterCode;
    // RQ2 both bytes move together, a same-cycle byte write included
    if (latchReq) begin
      next_converterCode = next_codeStage;
    end
  end

  // RQ4 straight binary code handed on unchanged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converterCode <= `ADLGC_CODE_RESET;
    end else begin
      converterCode <= next_converterCode;
    end
  end

  // ==========================================================
  // io line control

  always_comb begin
    next_ioDir   = ioDir;
    next_ioLevel = ioLevel;
    // RQ6 RQ8 direction bits
    if (regWrite && hitIoLo) begin
      next_ioDir = 2'(adlgcKeep(regWdata, `ADLGC_IOCTL_LO_MASK));
    end
    // RQ7 RQ8 level bits
    if (regWrite && hitIoHi) begin
      next_ioLevel = 2'(adlgcKeep(regWdata, `ADLGC_IOCTL_HI_MASK));
    end
  end

  // RQ10 both lines come up as inputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ioDir   <= `ADLGC_DIR_RESET;
      ioLevel <= `ADLGC_LVL_RESET;
    end else begin
      ioDir   <= next_ioDir;
      ioLevel <= next_ioLevel;
    end
  end

  // ==========================================================
  // register readback

  // RQ5 RQ12 readback with zeros in unused bits
  always_comb begin
    next_regRdata = regRdata;
    if (regRead) begin
      if (hitCodeLo) begin
        next_regRdata = codeStage[7:0];
      end else if (hitCodeHi) begin
        next_regRdata = adlgcKeep(8'({4'h0, codeStage[CODE_W-1:8]}), `ADLGC_CODE_HI_MASK);
      end else if (hitIoLo) begin
        next_regRdata = 8'({6'h00, ioDir});
      end else if (hitIoHi) begin
        next_regRdata = 8'({6'h00, ioLevel});
      end else begin
        next_regRdata = 8'h00;
      end
    end
  end

  // read byte stands until the next read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // ==========================================================
  // pin arbitration
  adlgc_pkg::adlgc_src_t src [2];
  logic [1:0] next_oe;
  logic [1:0] next_out;
  logic [1:0] pinOe;
  logic [1:0] pinOut;

  // RQ9 RQ11 ready beats alarm, alarm beats the control register
  function automatic adlgc_pkg::adlgc_src_t adlgcOwner(
    input logic readyHere,
    input logic alarmHere
  );
    if (readyHere) begin
      adlgcOwner = adlgc_pkg::ADLGC_SRC_MISC;
    end else if (alarmHere) begin
      adlgcOwner = adlgc_pkg::ADLGC_SRC_ALARM;
    end else begin
      adlgcOwner = adlgc_pkg::ADLGC_SRC_GPIO;
    end
  endfunction : adlgcOwner

  always_comb begin
    next_oe  = 2'h0;
    next_out = 2'h0;
    for (int i = 0; i < 2; i++) begin
      // RQ9 RQ11 priority select
      src[i] = adlgcOwner(sampleAvailableEnable && (sampleAvailableSelect == i[0]), alarmOwn[i]);
      unique case (src[i])
        adlgc_pkg::ADLGC_SRC_MISC: begin
          next_oe[i]  = 1'b1;
          next_out[i] = sampleAvailableLevel;
        end
        adlgc_pkg::ADLGC_SRC_ALARM: begin
          next_oe[i]  = 1'b1;
          next_out[i] = alarmLevel[i];
        end
        default: begin
          next_oe[i]  = ioDir[i];
          next_out[i] = ioLevel[i];
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOe  <= 2'h0;
      pinOut <= 2'h0;
    end else begin
      pinOe  <= next_oe;
      pinOut <= next_out;
    end
  end

  assign ioLineZeroOe  = pinOe[0];
  assign ioLineZeroOut = pinOut[0];
  assign ioLineOneOe   = pinOe[1];
  assign ioLineOneOut  = pinOut[1];

  // ==========================================================
  // input synchronisers
  logic [1:0] syncA;

  // only the second stage reads the first, pins reach no other logic
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA      <= 2'h0;
      ioLineSync <= 2'h0;
    end else begin
      syncA      <= {ioLineOneIn, ioLineZeroIn};
      ioLineSync <= syncA;
    end
  end

endmodule : adlgc_aux_dac_gpio

//--- testbench/adlgc_host.sv
// host model issuing byte register accesses and commands
`timescale 1ns/1ps
module adlgc_host (
  input  wire logic       clk,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic            regRead,
  output logic            cmdWrite,
  output logic      [6:0] regAddr,
  output logic      [7:0] regWdata,
  output logic      [7:0] cmdWdata
);
  initial {regWrite, regRead, cmdWrite, regAddr, regWdata, cmdWdata} = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
    @(posedge clk) {regWrite, regWdata} <= {1'b0, ~d};
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk) {regRead, regAddr} <= {1'b1, a};
    @(posedge clk) regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic cmd(input logic [7:0] d);
    @(posedge clk) {cmdWrite, cmdWdata} <= {1'b1, d};
    @(posedge clk) {cmdWrite, cmdWdata} <= {1'b0, ~d};
    #1;
  endtask : cmd
  task automatic load(input logic [11:0] c);
    wr(7'h30, c[7:0]);
    wr(7'h31, {4'h0, c[11:8]});
    cmd(8'h04);
  endtask : load
endmodule : adlgc_host

//--- testbench/adlgc_aux_dac_gpio_asserts.sv
// port checks for the aux converter and io line block
`timescale 1ns/1ps
module adlgc_aux_dac_gpio_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        regRead,
  input wire logic        cmdWrite,
  input wire logic        ioLineZeroOut,
  input wire logic        ioLineZeroOe,
  input wire logic        ioLineOneOut,
  input wire logic        ioLineOneOe,
  input wire logic        sampleAvailableEnable,
  input wire logic        sampleAvailableSelect,
  input wire logic        sampleAvailableLevel,
  input wire logic [1:0]  alarmOwn,
  input wire logic [1:0]  alarmLevel,
  input wire logic [6:0]  regAddr,
  input wire logic [7:0]  regRdata,
  input wire logic [7:0]  cmdWdata,
  input wire logic [11:0] converterCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_dr0; sampleAvailableEnable && !sampleAvailableSelect; endsequence
  sequence s_dr1; sampleAvailableEnable && sampleAvailableSelect; endsequence
  property p_hold; !(cmdWrite && cmdWdata[2]) |=> $stable(converterCode); endproperty
  a_hold: assert property (p_hold) else $error("code moved");
  property p_dr0; s_dr0 |=> ioLineZeroOe && ioLineZeroOut == $past(sampleAvailableLevel); endproperty
  a_dr0: assert property (p_dr0) else $error("line zero ready");
  property p_dr1; s_dr1 |=> ioLineOneOe && ioLineOneOut == $past(sampleAvailableLevel); endproperty
  a_dr1: assert property (p_dr1) else $error("line one ready");
  property p_al0; alarmOwn[0] && !sampleAvailableEnable |=> ioLineZeroOe && ioLineZeroOut == $past(alarmLevel[0]);
  endproperty
  a_al0: assert property (p_al0) else $error("line zero alarm");
  property p_al1; alarmOwn[1] && !sampleAvailableEnable |=> ioLineOneOe && ioLineOneOut == $past(alarmLevel[1]);
  endproperty
  a_al1: assert property (p_al1) else $error("line one alarm");
  property p_unm; regRead && (regAddr < 7'h30 || regAddr > 7'h33) |=> regRdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_rdhi; regRead && regAddr == 7'h31 |=> regRdata[7:4] == 4'h0; endproperty
  a_rdhi: assert property (p_rdhi) else $error("code high bits");
  property p_rdio; regRead && regAddr[6:1] == 6'h19 |=> regRdata[7:2] == 6'h00; endproperty
  a_rdio: assert property (p_rdio) else $error("control unused bits");
endmodule : adlgc_aux_dac_gpio_asserts
bind adlgc_aux_dac_gpio adlgc_aux_dac_gpio_asserts chk (.*);

//--- testbench/adlgc_aux_dac_gpio_tb.sv
// self-checking bench for the aux converter and io line block
`timescale 1ns/1ps
module adlgc_aux_dac_gpio_tb;
  logic clk, resetn, sEn, sSel, sLvl, rW, rR, cW, z, o, zO, zE, oO, oE;
  logic [6:0] rA;
  logic [7:0] rWd, rRd, cWd, d;
  logic [11:0] code;
  logic [1:0] aOwn, aLvl, sync;
  int nErrors = 0;
  int testsRun = 0;
  // released pins float high through the pull-ups
  assign z = zE ? zO : 1'b1;
  assign o = oE ? oO : 1'b1;
  adlgc_host host (.clk(clk), .regRdata(rRd), .regWrite(rW), .regRead(rR), .cmdWrite(cW), .regAddr(rA),
    .regWdata(rWd), .cmdWdata(cWd));
  adlgc_aux_dac_gpio uut (.clk(clk), .resetn(resetn), .regWrite(rW), .regRead(rR), .regAddr(rA),
    .regWdata(rWd), .regRdata(rRd), .cmdWrite(cW), .cmdWdata(cWd), .converterCode(code),
    .sampleAvailableEnable(sEn), .sampleAvailableSelect(sSel), .sampleAvailableLevel(sLvl),
    .alarmOwn(aOwn), .alarmLevel(aLvl), .ioLineZeroIn(z), .ioLineOneIn(o), .ioLineZeroOut(zO),
    .ioLineZeroOe(zE), .ioLineOneOut(oO), .ioLineOneOe(oE), .ioLineSync(sync));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    testsRun++;
    if (s !== e) begin
      nErrors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic finalReport;
    $display("errors=%0d checks=%0d", nErrors, testsRun);
    if (nErrors == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finalReport
  task automatic tReset;
    for (int a = 'h30; a < 'h35; a++) begin
      host.rd(7'(a), d);
      chk(d, 16'h0000);
    end
    chk({zE, oE}, 16'h0000);
  endtask : tReset
  task automatic tLatch;
    host.wr(7'h30, 8'hab);
    host.wr(7'h31, 8'hfc);
    host.cmd(8'hfb);
    chk(code, 16'h0000);
    host.rd(7'h31, d);
    chk(d, 16'h000c);
    host.cmd(8'h04);
    chk(code, 16'h0cab);
    host.load(12'hfff);
    chk(code, 16'h0fff);
  endtask : tLatch
  task automatic tPins;
    logic [6:0] v [3] = '{7'h68, 7'h6c, 7'h6f};
    logic [1:0] e [3] = '{2'h2, 2'h0, 2'h3};
    host.wr(7'h32, 8'hff);
    host.wr(7'h33, 8'hfe);
    host.rd(7'h33, d);
    chk(d, 16'h0002);
    chk({zE, oE, zO, oO}, 16'h000d);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) {aOwn, aLvl, sEn, sSel, sLvl} <= v[i];
      repeat (2) @(posedge clk);
      #1 chk({zO, oO}, e[i]);
    end
    @(posedge clk) {aOwn, sEn} <= 3'h0;
    repeat (4) @(posedge clk);
    #1 chk(sync, 16'h0002);
  endtask : tPins
  task automatic tRst2;
    @(posedge clk) resetn <= 1'b0;
    #1 chk({code, zE, oE}, 16'h0000);
    @(posedge clk) resetn <= 1'b1;
    host.rd(7'h30, d);
    chk(d, 16'h0000);
    chk(sync, 16'h0003);
  endtask : tRst2
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {resetn, aOwn, aLvl, sEn, sSel, sLvl} = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    tReset;
    tLatch;
    tPins;
    tRst2;
    finalReport;
  end
endmodule : adlgc_aux_dac_gpio_tb
